// ---- design/dbt_array.sv ----
// column storage with per-byte write enables
`timescale 1ns/100ps
module dbt_array import dbt_pkg::*; #(
	parameter int COL_W = 5
) (
	// clock and control
	input  wire logic   ref_clk_i,
	input  wire logic   sys_rst_i,
	input  wire logic   ce_i,
	// storage port
	dbt_mem_if.store    m
);
	localparam int DEPTH = 1 << COL_W;

	logic [DQ_W-1:0] mem_q [DEPTH];

	function automatic logic [DQ_W-1:0] byte_bits(input logic [MASK_W-1:0] be);
		logic [DQ_W-1:0] r;
		r = '0;
		for (int b = 0; b < MASK_W; b++) begin
			r[b*BYTE_W +: BYTE_W] = {BYTE_W{be[b]}};
		end
		return r;
	endfunction

	assign m.rdata = mem_q[m.addr];

	// =====================================================================
	// masked bytes keep their old value
	always_ff @(posedge ref_clk_i) begin
		if (ce_i && m.we) begin
			mem_q[m.addr] <= (mem_q[m.addr] & ~byte_bits(m.wbe))
				| (m.wdata & byte_bits(m.wbe));
		end
	end

	// =====================================================================
	// checks
	logic [DQ_W-1:0]   old_q;
	logic [COL_W-1:0]  paddr_q;
	logic [MASK_W-1:0] pbe_q;
	logic              pwe_q;

	always_ff @(posedge ref_clk_i) begin
		old_q   <= mem_q[m.addr];
		paddr_q <= m.addr;
		pbe_q   <= m.wbe;
		pwe_q   <= ce_i && m.we;
	end

	a_mask_keeps_byte: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		pwe_q |-> ((mem_q[paddr_q] ^ old_q) & ~byte_bits(pbe_q)) == '0)
		else $error("masked byte changed on write");

	a_write_takes_data: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		ce_i && m.we |=> (mem_q[paddr_q] & byte_bits(pbe_q)) == ($past(m.wdata) & byte_bits(pbe_q)))
		else $error("unmasked byte not written");

endmodule

// ---- design/dbt_core.sv ----
// burst read and write engine of a synchronous dram, sampled on a slow link clock
`timescale 1ns/100ps
module dbt_core import dbt_pkg::*; #(
	parameter int ADD_LAT  = 0,
	parameter int COL_LAT  = 5,
	parameter int WCOL_LAT = 5,
	parameter int COL_W    = 5
) (
	// clock, reset, enable
	input  wire logic              ref_clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              ce_i,
	// command and address from the controller
	input  wire logic              link_ck_i,
	input  wire logic              cs_n_i,
	input  wire logic [CMD_W-1:0]  cmd_n_i,
	input  wire logic [BA_W-1:0]   ba_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	// data and strobe pins
	input  wire logic [DQ_W-1:0]   dq_i,
	output logic      [DQ_W-1:0]   dq_o,
	output logic                   dq_oe_o,
	input  wire logic              dqs_i,
	output logic                   dqs_o,
	output logic                   dqs_oe_o,
	input  wire logic [MASK_W-1:0] write_byte_mask_i
);
	localparam int READ_LATENCY  = ADD_LAT + COL_LAT;
	localparam int WRITE_LATENCY = ADD_LAT + WCOL_LAT;
	localparam int MAX_CYC       = ((READ_LATENCY > WRITE_LATENCY) ?
		READ_LATENCY : WRITE_LATENCY) + int'(LEN8);

	// =====================================================================
	// input synchroniser, three stages
	logic [IN_W-1:0] s1_q;
	logic [IN_W-1:0] s2_q;
	logic [IN_W-1:0] s3_q;
	logic            ck_q;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (ce_i) begin
			s1_q <= {link_ck_i, cs_n_i, cmd_n_i, ba_i, addr_i, write_byte_mask_i, dq_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	logic agree;
	logic rise;
	logic fall;

	assign agree = (s2_q[CK_POS] == s3_q[CK_POS]);
	assign rise  = agree && s3_q[CK_POS] && !ck_q;
	assign fall  = agree && !s3_q[CK_POS] && ck_q;

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ck_q <= 1'b0;
		end else if (ce_i && agree) begin
			ck_q <= s3_q[CK_POS];
		end
	end

	logic              cs3_n;
	logic [CMD_W-1:0]  cmd3;
	logic [BA_W-1:0]   ba3;
	logic [ADDR_W-1:0] addr3;

	assign cs3_n = s3_q[CS_POS];
	assign cmd3  = s3_q[CMD_LSB +: CMD_W];
	assign ba3   = s3_q[BA_LSB +: BA_W];
	assign addr3 = s3_q[ADDR_LSB +: ADDR_W];

	// =====================================================================
	// helpers
	function automatic logic [2:0] burst_len(input logic [1:0] mode, input logic bsel);
		case (mode)
			BF_OTF:   burst_len = bsel ? LEN8 : LEN4;
			BF_CHOP4: burst_len = LEN4;
			default:  burst_len = LEN8;
		endcase
	endfunction

	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] base,
		input logic [BEAT_W-1:0] beat);
		burst_col = {base[COL_W-1:BEAT_W], BEAT_W'(base[BEAT_W-1:0] + beat)};
	endfunction

	// =====================================================================
	// burst state machine, counted in link clock cycles
	dbt_state_t        st_q;
	logic [CYC_W-1:0]  cyc_q;
	logic [2:0]        len_q;
	logic [COL_W-1:0]  col_q;
	logic [1:0]        mode_q;
	logic [CYC_W-1:0]  nc;
	logic [CYC_W-1:0]  lat;
	logic [CYC_W-1:0]  end_c;
	logic              take;

	assign nc    = CYC_W'(cyc_q + 1'b1);
	assign lat   = (st_q == ST_READ) ? CYC_W'(READ_LATENCY) : CYC_W'(WRITE_LATENCY);
	assign end_c = CYC_W'(lat + len_q);
	assign take  = rise && (st_q == ST_IDLE) && !cs3_n && (cmd3 == CMD_RD || cmd3 == CMD_WR);

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mode_q <= MODE_RST;
		end else if (ce_i && rise && st_q == ST_IDLE && !cs3_n
			&& cmd3 == CMD_MRS && ba3 == BA_MODE0) begin
			mode_q <= addr3[BF_LSB +: 2];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			st_q  <= ST_IDLE;
			cyc_q <= '0;
			len_q <= LEN8;
			col_q <= '0;
		end else if (ce_i && rise) begin
			case (st_q)
				ST_IDLE: begin
					cyc_q <= '0;
					if (take) begin
						st_q  <= (cmd3 == CMD_RD) ? ST_READ : ST_WRITE;
						len_q <= burst_len(mode_q, addr3[BSEL_BIT]);
						col_q <= addr3[COL_W-1:0];
					end
				end
				ST_READ, ST_WRITE: begin
					cyc_q <= nc;
					// ends on the count alone, whatever the strobe did
					if (nc == end_c) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// =====================================================================
	// beat position on each link edge
	logic              win;
	logic [CYC_W-1:0]  rel;
	logic [BEAT_W-1:0] beat;

	always_comb begin
		rel  = rise ? CYC_W'(nc - lat) : CYC_W'(cyc_q - lat);
		win  = (st_q != ST_IDLE) && (rise || fall) && (rel < CYC_W'(len_q))
			&& ((rise ? nc : cyc_q) >= lat);
		beat = {rel[1:0], fall};
	end

	dbt_mem_if #(.COL_W(COL_W)) mem ();

	// write beats land on every edge, mask only matters here
	assign mem.we    = (st_q == ST_WRITE) && win;
	assign mem.addr  = burst_col(col_q, beat);
	assign mem.wdata = s3_q[DQ_LSB +: DQ_W];
	assign mem.wbe   = ~s3_q[WBM_LSB +: MASK_W];

	dbt_array #(.COL_W(COL_W)) u_array (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.m         (mem.store)
	);

	// =====================================================================
	// read drivers
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			dq_o     <= '0;
			dq_oe_o  <= 1'b0;
			dqs_o    <= 1'b0;
			dqs_oe_o <= 1'b0;
		end else if (ce_i && st_q == ST_READ) begin
			if (rise && nc == CYC_W'(READ_LATENCY - 1)) begin
				dqs_oe_o <= 1'b1;
				dqs_o    <= 1'b0;
			end
			if (win) begin
				dq_oe_o <= 1'b1;
				dq_o    <= mem.rdata;
				dqs_o   <= rise;
			end
			if (rise && nc == end_c) begin
				dq_oe_o  <= 1'b0;
				dqs_oe_o <= 1'b0;
				dqs_o    <= 1'b0;
			end
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i || !ce_i);

	a_otf_select: assert property (take && mode_q == BF_OTF
		|=> len_q == ($past(addr3[BSEL_BIT]) ? LEN8 : LEN4))
		else $error("per-command burst select not honoured");
	a_column_only: assert property (take |=> col_q == $past(addr3[COL_W-1:0]))
		else $error("column not taken from low address bits");
	a_fixed_eight: assert property (take && mode_q == BF_FIXED8 |=> len_q == LEN8)
		else $error("fixed mode did not give eight beats");
	a_fixed_chop: assert property (take && mode_q == BF_CHOP4 |=> len_q == LEN4)
		else $error("chop mode did not give four beats");
	a_preamble_start: assert property (st_q == ST_READ && rise
		&& nc == CYC_W'(READ_LATENCY - 1) |=> dqs_oe_o && !dqs_o && !dq_oe_o)
		else $error("strobe preamble not started");
	a_release_point: assert property (st_q == ST_READ && rise && nc == end_c
		|=> !dqs_oe_o && !dq_oe_o ##1 st_q == ST_IDLE)
		else $error("outputs not released at end of read");
	a_no_hang: assert property (st_q != ST_IDLE |-> cyc_q <= CYC_W'(MAX_CYC))
		else $error("burst engine stuck");
	a_mask_unused_read: assert property (st_q != ST_WRITE |-> !mem.we)
		else $error("array written outside a write burst");
	a_read_latency: assert property (st_q == ST_READ && rise
		&& nc == CYC_W'(READ_LATENCY) |=> dq_oe_o && dqs_o)
		else $error("read data not out at read latency");

	c_read_eight: cover property (take && cmd3 == CMD_RD && burst_len(mode_q,
		addr3[BSEL_BIT]) == LEN8);
	c_read_chop: cover property (take && cmd3 == CMD_RD && burst_len(mode_q,
		addr3[BSEL_BIT]) == LEN4);
	c_write_masked: cover property (mem.we && mem.wbe != {MASK_W{1'b1}});

endmodule

// ---- design/dbt_mem_if.sv ----
// port between the burst engine and its storage array
`timescale 1ns/100ps
interface dbt_mem_if import dbt_pkg::*; #(
	parameter int COL_W = 5
) ();
	logic              we;
	logic [COL_W-1:0]  addr;
	logic [DQ_W-1:0]   wdata;
	logic [MASK_W-1:0] wbe;
	logic [DQ_W-1:0]   rdata;

	modport core  (output we, output addr, output wdata, output wbe, input rdata);
	modport store (input we, input addr, input wdata, input wbe, output rdata);
endinterface

// ---- design/dbt_pkg.sv ----
// constants and types shared by the dram burst timing block
package dbt_pkg;

	// =====================================================================
	// widths
	localparam int DQ_W     = 16;
	localparam int BYTE_W   = 8;
	localparam int MASK_W   = DQ_W / BYTE_W;
	localparam int ADDR_W   = 13;
	localparam int BA_W     = 3;
	localparam int CMD_W    = 3;
	localparam int BEAT_W   = 3;
	localparam int CYC_W    = 6;
	localparam int BSEL_BIT = 12;
	localparam int BF_LSB   = 0;

	// =====================================================================
	// positions in the synchronised input bundle
	localparam int DQ_LSB   = 0;
	localparam int WBM_LSB  = DQ_LSB + DQ_W;
	localparam int ADDR_LSB = WBM_LSB + MASK_W;
	localparam int BA_LSB   = ADDR_LSB + ADDR_W;
	localparam int CMD_LSB  = BA_LSB + BA_W;
	localparam int CS_POS   = CMD_LSB + CMD_W;
	localparam int CK_POS   = CS_POS + 1;
	localparam int IN_W     = CK_POS + 1;

	// =====================================================================
	// commands as {ras_n, cas_n, we_n}, mode field codes, burst lengths
	localparam logic [2:0] CMD_MRS    = 3'h0;
	localparam logic [2:0] CMD_WR     = 3'h4;
	localparam logic [2:0] CMD_RD     = 3'h5;
	localparam logic [2:0] BA_MODE0   = 3'h0;
	localparam logic [1:0] BF_FIXED8  = 2'h0;
	localparam logic [1:0] BF_OTF     = 2'h1;
	localparam logic [1:0] BF_CHOP4   = 2'h2;
	localparam logic [1:0] MODE_RST   = BF_FIXED8;
	localparam logic [2:0] LEN8       = 3'h4;
	localparam logic [2:0] LEN4       = 3'h2;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10
	} dbt_state_t;

endpackage

// ---- test/dbt_core_tb_top.sv ----
// self-checking bench of the burst read and write engine
`timescale 1ns/100ps
module dbt_core_tb_top import dbt_pkg::*; ();
	localparam int ADD_LAT_T = 1;
	localparam int COL_LAT_T = 5;
	localparam int WCOL_LAT_T = 5;

	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        run = 1'b0;
	logic        link_ck, cs_n, dqs_in, dqs_out, dq_oe, dqs_oe;
	logic [2:0]  cmd_n, ba;
	logic [12:0] addr, a;
	logic [15:0] dq_in, dq_out;
	logic [1:0]  mask, mode = MODE_RST;
	logic [15:0] mem [0:31];
	int          seed, bad_count = 0, n_checks = 0;

	always #50 ref_clk = ~ref_clk;

	dbt_core #(.ADD_LAT(ADD_LAT_T), .COL_LAT(COL_LAT_T), .WCOL_LAT(WCOL_LAT_T),
		.COL_W(5)) dut (
		.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .ce_i(1'b1), .link_ck_i(link_ck),
		.cs_n_i(cs_n), .cmd_n_i(cmd_n), .ba_i(ba), .addr_i(addr), .dq_i(dq_in),
		.dq_o(dq_out), .dq_oe_o(dq_oe), .dqs_i(dqs_in), .dqs_o(dqs_out),
		.dqs_oe_o(dqs_oe), .write_byte_mask_i(mask));

	dbt_ctl_model ctl (
		.ref_clk_i(ref_clk), .run_i(run), .rd_dq_i(dq_out), .rd_oe_i(dq_oe),
		.rd_dqs_i(dqs_out), .rd_dqs_oe_i(dqs_oe), .link_ck_o(link_ck), .cs_n_o(cs_n),
		.cmd_n_o(cmd_n), .ba_o(ba), .addr_o(addr), .dq_o(dq_in), .dqs_o(dqs_in),
		.mask_o(mask));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [4:0] col(input logic [4:0] c, input int b);
		return {c[4:3], c[2:0] + b[2:0]};
	endfunction

	function automatic int blen(input logic sel);
		if (mode == BF_CHOP4) return int'(LEN4);
		if (mode == BF_OTF) return sel ? int'(LEN8) : int'(LEN4);
		return int'(LEN8);
	endfunction

	function automatic logic [127:0] rnd128();
		return {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction

	// =====================================================================
	// one command through the model, then compare every sampled half cycle
	task automatic do_op(input logic [2:0] op, input logic [2:0] bank, input logic [12:0] adr,
		input logic [127:0] wd, input logic [15:0] wm);
		int n;
		int lat;
		logic [4:0] c;
		logic [18:0] got;
		c = adr[4:0];
		n = (op == CMD_MRS) ? 0 : blen(adr[BSEL_BIT]);
		// a mode load is watched over a write-latency window with no beats, so every snapshot is fresh
		lat = (op == CMD_RD) ? ADD_LAT_T + COL_LAT_T : ADD_LAT_T + WCOL_LAT_T;
		ctl.xfer(op, bank, adr, lat, n, wd, wm);
		if (op == CMD_MRS && bank == BA_MODE0) mode = adr[1:0];
		if (op == CMD_WR)
			for (int k = 0; k < 4 * n; k++) if (!wm[k]) mem[col(c, k / 2)][8 * (k % 2) +: 8] = wd[8 * k +: 8];
		chk("early drive", 19'h0, {18'h0, ctl.drv_early});
		for (int b = -2; b <= 2 * n; b++) begin
			got = ctl.snap[b + 2];
			if (op != CMD_RD)
				chk("idle oe", 19'h0, got & 19'h6_0000);
			else if (b < 0)
				chk("preamble", 19'h2_0000, got & 19'h7_0000);
			else if (b == 2 * n)
				chk("release", 19'h0, got & 19'h6_0000);
			else
				chk("read beat", {2'b11, ~b[0], mem[col(c, b)]}, got);
		end
	endtask

	initial begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		wrap_up();
	end

	initial begin
		seed = 73635;
		repeat (5) @(negedge ref_clk);
		sys_rst <= 1'b0;
		repeat (5) @(negedge ref_clk);
		run <= 1'b1;
		// fill all columns; burst-select low must still give eight beats
		for (int i = 0; i < 4; i++) do_op(CMD_WR, 3'h0, 13'(i * 8), rnd128(), 16'h0);
		do_op(CMD_MRS, 3'h1, 13'h0002, 128'h0, 16'h0);
		do_op(CMD_RD, 3'h0, 13'h000d, 128'h0, 16'h0);
		for (int m = 0; m < 4; m++) begin
			do_op(CMD_MRS, BA_MODE0, {11'($random(seed)), m[1:0]}, 128'h0, 16'h0);
			repeat (8) begin
				a = 13'($random(seed));
				do_op(a[5] ? CMD_RD : CMD_WR, 3'($random(seed)), a, rnd128(), 16'($random(seed)));
			end
		end
		// reset mid-run returns the mode field to always eight beats
		do_op(CMD_MRS, BA_MODE0, 13'h0002, 128'h0, 16'h0);
		run <= 1'b0;
		sys_rst <= 1'b1;
		repeat (3) @(negedge ref_clk);
		sys_rst <= 1'b0;
		mode = MODE_RST;
		repeat (6) @(negedge ref_clk);
		run <= 1'b1;
		do_op(CMD_RD, 3'h0, 13'h0011, 128'h0, 16'h0);
		chk("link wait", 19'h0, {18'h0, ctl.hung});
		wrap_up();
	end
endmodule

// ---- test/dbt_ctl_model.sv ----
// controller side model: link clock, commands, write beats and read sampling
`timescale 1ns/100ps
module dbt_ctl_model (
	// clock and run control
	input  wire logic        ref_clk_i,
	input  wire logic        run_i,
	// device outputs
	input  wire logic [15:0] rd_dq_i,
	input  wire logic        rd_oe_i,
	input  wire logic        rd_dqs_i,
	input  wire logic        rd_dqs_oe_i,
	// pins toward the device
	output logic             link_ck_o,
	output logic             cs_n_o,
	output logic [2:0]       cmd_n_o,
	output logic [2:0]       ba_o,
	output logic [12:0]      addr_o,
	output logic [15:0]      dq_o,
	output logic             dqs_o,
	output logic [1:0]       mask_o
);
	logic [2:0]  ph_q = 3'h0;
	logic [18:0] snap [0:10];
	logic        drv_early;
	logic        hung = 1'b0;

	initial begin
		{cs_n_o, cmd_n_o, ba_o, addr_o} = {4'hf, 16'h0000};
		{dq_o, dqs_o, mask_o} = 19'h0;
	end

	// link clock runs free once started, eight system cycles a period
	always @(posedge ref_clk_i) ph_q <= run_i ? ph_q + 3'h1 : 3'h0;
	always @(negedge ref_clk_i) link_ck_o <= run_i && (ph_q < 3'h4);

	// =====================================================================
	// one command with its data beats; pins change midway between link edges
	task automatic xfer(input logic [2:0] op, input logic [2:0] bank, input logic [12:0] adr,
		input int lat, input int n, input logic [127:0] wd, input logic [15:0] wm);
		int b;
		int k;
		k = 0;
		drv_early = 1'b0;
		do begin
			@(negedge ref_clk_i);
			k++;
		end while (ph_q != 3'h6 && k < 16);
		hung = hung | (k >= 16);
		// next command only after the burst ends, far past column spacing
		{cs_n_o, cmd_n_o, ba_o, addr_o} <= {1'b0, op, bank, adr};
		// no precharge or activate is ever sent, and nothing follows a read
		// before its burst is over, well past additive plus four cycles
		for (int i = 0; i <= 2 * (lat + n) + 1; i++) begin
			k = 0;
			do begin
				@(negedge ref_clk_i);
				k++;
			end while (ph_q[1:0] != 2'h2 && k < 8);
			hung = hung | (k >= 8);
			b = i + 1 - 2 * lat;
			if (op == 3'h4 && b >= 0 && b < 2 * n) begin
				dq_o <= wd[16 * b +: 16];
				mask_o <= wm[2 * b +: 2];
			end else begin
				dq_o <= ~dq_o;
				mask_o <= ~mask_o;
			end
			// strobe carries no timing for the device; toggled freely
			dqs_o <= ~dqs_o;
			if (i == 0) begin
				{cs_n_o, cmd_n_o} <= 4'hf;
				{ba_o, addr_o} <= ~{ba_o, addr_o};
			end
			b = i - 1 - 2 * lat;
			if (b >= -2)
				snap[b + 2] = {rd_oe_i, rd_dqs_oe_i, rd_dqs_i, rd_dq_i};
			else
				drv_early = drv_early | rd_oe_i | rd_dqs_oe_i;
		end
	endtask
endmodule
